// [design/bgpc_cfg.svh]
/*
  Offsets, field positions, reset values and identity constants for the
  board control register block.
  Assumes it is included by bare name; definitions only.
*/
`ifndef BGPC_CFG_SVH
`define BGPC_CFG_SVH

`define BGPC_ADDR_INDEX      8'h62
`define BGPC_ADDR_DATA       8'h66

`define BGPC_IDX_PORT1       4'h2
`define BGPC_IDX_PORT2       4'h3
`define BGPC_IDX_PWM         4'h8
`define BGPC_IDX_PN_LOW      4'h9
`define BGPC_IDX_STATUS      4'ha
`define BGPC_IDX_PN_HIGH     4'hb

`define BGPC_INDEX_RESET     4'ha
`define BGPC_VERSION         4'h0
`define BGPC_PORT1_RESET     8'h00
`define BGPC_PORT2_RESET     8'h00
`define BGPC_PWM_RESET       4'h0

`define BGPC_P2_DIR_BIT      7
`define BGPC_P1_HIGH_DIR_BIT 6
`define BGPC_P1_LOW_DIR_BIT  5
`define BGPC_P2_OUT_ONLY_BIT 2
`define BGPC_ST_ROM_SEL_BIT  7
`define BGPC_ST_VOLTAGE_ID_BIT5_INV_BIT     5

// part number bytes, values arbitrary
`define BGPC_PN_LOW          8'h12
`define BGPC_PN_HIGH         8'h34

`endif

// [design/bgpc_pkg.sv]
/*
  Types for the board control register block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package bgpc_pkg;
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bgpc_io_req_s;

  typedef struct packed {
    logic [7:0] p1_in;
    logic [4:0] p2_in;
    logic       rom_sel;
    logic       voltage_id_bit5_inv;
  } bgpc_pins_s;
endpackage

// [design/bgpc_sync.sv]
/*
  Two-stage synchroniser for a vector of pin levels.
  Assumes pins are asynchronous to clk; stage one read only by stage two.
*/
`timescale 1ns/1ps
module bgpc_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_q;

  always_comb begin
    next_stage1 = resetn ? d : '0;
    next_q      = resetn ? stage1 : '0;
  end

  always_ff @(posedge clk) begin
    stage1 <= next_stage1;
    q      <= next_q;
  end
endmodule

// [design/bgpc_regs.sv]
/*
  Board control registers behind an index/data I/O port pair: GPIO ports
  1 and 2 with direction control, PWM width, status and part number.
  Assumes single-cycle I/O strobes on clk from the host I/O decoder.
*/
`timescale 1ns/1ps
`include "bgpc_cfg.svh"
module bgpc_regs (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire bgpc_pkg::bgpc_io_req_s io_req,
  output logic      [7:0]           io_rdata,
  input  wire bgpc_pkg::bgpc_pins_s  pins,
  output logic      [7:0]           port1_data_bits_o,
  output logic      [7:0]           port1_data_bits_oe,
  output logic      [1:0]           port2_pin_o,
  output logic      [1:0]           port2_pin_oe,
  output logic                      port2_out_only_pin,
  output logic      [3:0]           pwm_width
);
  localparam int SW = 15;

  logic [3:0]    index;
  logic [7:0]    port1;
  logic [7:0]    port2;
  logic [3:0]    pwm;
  logic [3:0]    next_index;
  logic [7:0]    next_port1;
  logic [7:0]    next_port2;
  logic [3:0]    next_pwm;
  logic [7:0]    next_rdata;
  logic [SW-1:0] pin_raw;
  logic [SW-1:0] pin_s;
  logic [7:0]    p1_in;
  logic [4:0]    p2_in;
  logic          rom_sel;
  logic          voltage_id_bit5_inv;
  logic [7:0]    p1_oe;
  logic [1:0]    p2_oe;
  logic          wr_idx;
  logic          wr_dat;
  logic          rd_dat;

  assign pin_raw = {pins.p1_in, pins.p2_in, pins.rom_sel, pins.voltage_id_bit5_inv};

  bgpc_sync #(.W(SW)) bgpc_sync_i (
    .clk    (clk),
    .resetn (resetn),
    .d      (pin_raw),
    .q      (pin_s)
  );

  assign p1_in   = pin_s[14:7];
  assign p2_in   = pin_s[6:2];
  assign rom_sel = pin_s[1];
  assign voltage_id_bit5_inv    = pin_s[0];

  assign wr_idx = io_req.wr && (io_req.addr == `BGPC_ADDR_INDEX);
  assign wr_dat = io_req.wr && (io_req.addr == `BGPC_ADDR_DATA);
  assign rd_dat = io_req.rd && (io_req.addr == `BGPC_ADDR_DATA);

  assign p1_oe = {{3{port2[`BGPC_P1_HIGH_DIR_BIT]}},
                  {5{port2[`BGPC_P1_LOW_DIR_BIT]}}};
  assign p2_oe = {2{port2[`BGPC_P2_DIR_BIT]}};

  always_comb begin
    next_index = index;
    next_port1 = port1;
    next_port2 = port2;
    next_pwm   = pwm;
    if (wr_idx) begin
      next_index = io_req.wdata[3:0];
    end
    if (wr_dat) begin
      case (index)
        `BGPC_IDX_PORT1: begin
          next_port1 = (io_req.wdata & p1_oe) | (port1 & ~p1_oe);
        end
        `BGPC_IDX_PORT2: begin
          next_port2[7:5] = io_req.wdata[7:5];
          next_port2[2]   = io_req.wdata[2];
          next_port2[1:0] = (io_req.wdata[1:0] & p2_oe) |
                            (port2[1:0] & ~p2_oe);
          next_port2[4:3] = 2'h0;
        end
        `BGPC_IDX_PWM: begin
          next_pwm = io_req.wdata[3:0];
        end
        default: begin
          next_pwm = pwm;
        end
      endcase
    end
    if (!resetn) begin
      next_index = `BGPC_INDEX_RESET;
      next_port1 = `BGPC_PORT1_RESET;
      next_port2 = `BGPC_PORT2_RESET;
      next_pwm   = `BGPC_PWM_RESET;
    end
  end

  always_comb begin
    next_rdata = io_rdata;
    if (io_req.rd && io_req.addr == `BGPC_ADDR_INDEX) begin
      next_rdata = {`BGPC_VERSION, index};
    end else if (rd_dat) begin
      case (index)
        `BGPC_IDX_PORT1: begin
          next_rdata = (port1 & p1_oe) | (p1_in & ~p1_oe);
        end
        `BGPC_IDX_PORT2: begin
          next_rdata = {port2[7:5], p2_in[4:3], port2[2],
                        (port2[1:0] & p2_oe) | (p2_in[1:0] & ~p2_oe)};
        end
        `BGPC_IDX_PWM: begin
          next_rdata = {4'h0, pwm};
        end
        `BGPC_IDX_PN_LOW: begin
          next_rdata = `BGPC_PN_LOW;
        end
        `BGPC_IDX_PN_HIGH: begin
          next_rdata = `BGPC_PN_HIGH;
        end
        `BGPC_IDX_STATUS: begin
          next_rdata = 8'h00;
          next_rdata[`BGPC_ST_ROM_SEL_BIT] = rom_sel;
          next_rdata[`BGPC_ST_VOLTAGE_ID_BIT5_INV_BIT]    = ~voltage_id_bit5_inv;
        end
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end
    if (!resetn) begin
      next_rdata = 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    index    <= next_index;
    port1    <= next_port1;
    port2    <= next_port2;
    pwm      <= next_pwm;
    io_rdata <= next_rdata;
  end

  assign port1_data_bits_o  = port1;
  assign port1_data_bits_oe = p1_oe;
  assign port2_pin_o        = port2[1:0];
  assign port2_pin_oe       = p2_oe;
  assign port2_out_only_pin = port2[`BGPC_P2_OUT_ONLY_BIT];
  assign pwm_width          = pwm;

  AST_P2_RESET: assert property (@(posedge clk)
    !resetn |=> port2 == `BGPC_PORT2_RESET && port2_pin_oe == 2'h0)
    else $error("port2 register not zero after reset");

  AST_P2_IN_IGNORE: assert property (@(posedge clk)
    disable iff (!resetn)
    wr_dat && index == `BGPC_IDX_PORT2 && !port2[`BGPC_P2_DIR_BIT] &&
    !io_req.wdata[`BGPC_P2_DIR_BIT]
    |=> $stable(port2_pin_o))
    else $error("write changed input-mode port2 bits");

  AST_P2_OUT: assert property (@(posedge clk)
    disable iff (!resetn)
    wr_dat && index == `BGPC_IDX_PORT2 && port2[`BGPC_P2_DIR_BIT]
    |=> port2_pin_o == $past(io_req.wdata[1:0]))
    else $error("output port2 bits did not take write");

  AST_P2_OUT_ONLY: assert property (@(posedge clk)
    disable iff (!resetn)
    wr_dat && index == `BGPC_IDX_PORT2
    |=> port2_out_only_pin == $past(io_req.wdata[`BGPC_P2_OUT_ONLY_BIT]))
    else $error("port2 bit 2 did not take write");

  AST_PWM: assert property (@(posedge clk)
    disable iff (!resetn)
    wr_dat && index == `BGPC_IDX_PWM
    |=> pwm_width == $past(io_req.wdata[3:0]))
    else $error("pwm width not updated");

  AST_VOLTAGE_ID_BIT5_INV: assert property (@(posedge clk)
    disable iff (!resetn)
    rd_dat && index == `BGPC_IDX_STATUS
    |=> io_rdata[`BGPC_ST_VOLTAGE_ID_BIT5_INV_BIT] == !$past(voltage_id_bit5_inv))
    else $error("status vid bit not inverted");

  AST_VERSION: assert property (@(posedge clk)
    disable iff (!resetn)
    io_req.rd && io_req.addr == `BGPC_ADDR_INDEX
    |=> io_rdata == {`BGPC_VERSION, $past(index)})
    else $error("index read wrong");

  AST_RO_WRITE: assert property (@(posedge clk)
    disable iff (!resetn)
    wr_dat && (index == `BGPC_IDX_PN_LOW || index == `BGPC_IDX_STATUS ||
               index == `BGPC_IDX_PN_HIGH)
    |=> $stable(port1) && $stable(port2) && $stable(pwm_width))
    else $error("read-only write changed state");

  AST_P1_DIR: assert property (@(posedge clk)
    disable iff (!resetn)
    wr_dat && index == `BGPC_IDX_PORT2
    |=> port1_data_bits_oe ==
        {{3{$past(io_req.wdata[`BGPC_P1_HIGH_DIR_BIT])}},
         {5{$past(io_req.wdata[`BGPC_P1_LOW_DIR_BIT])}}})
    else $error("port1 direction wrong");
endmodule

// [test/test_board_gpio_pwm_control_regs.sv]
/*
  Bench for the board control registers: index/data access, GPIO
  direction and data, PWM width, status, part number, ignored writes.
  Assumes the design files and bgpc_cfg.svh are compiled before it.
*/
`timescale 1ns/1ps
`include "bgpc_cfg.svh"
module test_board_gpio_pwm_control_regs;
  logic                   clk;
  logic                   resetn;
  bgpc_pkg::bgpc_io_req_s req;
  bgpc_pkg::bgpc_pins_s   pins;
  logic [7:0]             rdata;
  logic [7:0]             p1_o;
  logic [7:0]             p1_oe;
  logic [1:0]             p2_o;
  logic [1:0]             p2_oe;
  logic                   p2_oo;
  logic [3:0]             pwm;
  int                     mismatches;
  int                     check_count;
  int                     cycles;

  bgpc_regs bgpc_regs_i (
    .clk                (clk),
    .resetn             (resetn),
    .io_req             (req),
    .io_rdata           (rdata),
    .pins               (pins),
    .port1_data_bits_o  (p1_o),
    .port1_data_bits_oe (p1_oe),
    .port2_pin_o        (p2_o),
    .port2_pin_oe       (p2_oe),
    .port2_out_only_pin (p2_oo),
    .pwm_width          (pwm)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic final_report();
    $display("mismatches %0d checks %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // run should need well under 400 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      $display("BAD %0t timeout", $time);
      final_report();
    end
  end

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(posedge clk);
    #1;
    req.wr = 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    req.rd = 1'b1;
    req.addr = a;
    @(posedge clk);
    #1;
    req.rd = 1'b0;
    cmp(rdata, exp);
    @(posedge clk);
    #1;
  endtask

  task automatic wreg(input logic [3:0] idx, input logic [7:0] d);
    wr(`BGPC_ADDR_INDEX, {4'h0, idx});
    wr(`BGPC_ADDR_DATA, d);
  endtask

  task automatic rreg(input logic [3:0] idx, input logic [7:0] exp);
    wr(`BGPC_ADDR_INDEX, {4'h0, idx});
    rd(`BGPC_ADDR_DATA, exp);
  endtask

  initial begin
    req = '0;
    pins = '0;
    resetn = 1'b0;
    mismatches = 0;
    check_count = 0;
    cycles = 0;
    repeat (2) @(posedge clk);
    #1;
    resetn = 1'b1;
    cmp(p1_oe, 8'h00);
    cmp({6'h00, p2_oe}, 8'h00);
    cmp({4'h0, pwm}, 8'h00);
    rd(`BGPC_ADDR_INDEX, 8'h0a);
    wr(`BGPC_ADDR_INDEX, 8'hf3);
    rd(`BGPC_ADDR_INDEX, 8'h03);
    rd(`BGPC_ADDR_DATA, 8'h00);
    pins.p2_in = 5'h1b;
    wreg(`BGPC_IDX_PORT2, 8'h07);
    rreg(`BGPC_IDX_PORT2, 8'h1f);
    cmp({7'h00, p2_oo}, 8'h01);
    cmp({6'h00, p2_oe}, 8'h00);
    pins.p2_in = 5'h09;
    // first write flips direction, second stores the output bits
    wreg(`BGPC_IDX_PORT2, 8'he6);
    wr(`BGPC_ADDR_DATA, 8'he6);
    rreg(`BGPC_IDX_PORT2, 8'hee);
    cmp({6'h00, p2_o}, 8'h02);
    cmp({6'h00, p2_oe}, 8'h03);
    cmp(p1_oe, 8'hff);
    wreg(`BGPC_IDX_PORT2, 8'h20);
    cmp(p1_oe, 8'h1f);
    pins.p1_in = 8'h3c;
    wreg(`BGPC_IDX_PORT1, 8'ha5);
    rreg(`BGPC_IDX_PORT1, 8'h25);
    cmp({3'h0, p1_o[4:0]}, 8'h05);
    wreg(`BGPC_IDX_PORT2, 8'h40);
    cmp(p1_oe, 8'he0);
    wr(`BGPC_ADDR_INDEX, {4'h0, `BGPC_IDX_PORT1});
    pins.p1_in = 8'hc3;
    // pin change not yet through the synchroniser
    rd(`BGPC_ADDR_DATA, 8'h1c);
    repeat (2) @(posedge clk);
    #1;
    rd(`BGPC_ADDR_DATA, 8'h03);
    // high group drives, low group keeps its stored bits
    wr(`BGPC_ADDR_DATA, 8'h5a);
    rd(`BGPC_ADDR_DATA, 8'h43);
    cmp(p1_o, 8'h45);
    wreg(`BGPC_IDX_PWM, 8'hfa);
    rreg(`BGPC_IDX_PWM, 8'h0a);
    cmp({4'h0, pwm}, 8'h0a);
    pins.rom_sel = 1'b1;
    rreg(`BGPC_IDX_STATUS, 8'ha0);
    pins.rom_sel = 1'b0;
    pins.voltage_id_bit5_inv = 1'b1;
    rreg(`BGPC_IDX_STATUS, 8'h00);
    wr(`BGPC_ADDR_DATA, 8'hff);
    rd(`BGPC_ADDR_DATA, 8'h00);
    rreg(`BGPC_IDX_PN_LOW, `BGPC_PN_LOW);
    wr(`BGPC_ADDR_DATA, 8'h00);
    rd(`BGPC_ADDR_DATA, `BGPC_PN_LOW);
    // unused index reads as zero
    rreg(4'h5, 8'h00);
    rreg(`BGPC_IDX_PN_HIGH, `BGPC_PN_HIGH);
    cmp({4'h0, pwm}, 8'h0a);
    cmp(p1_o, 8'h45);
    // unmapped address: write ignored, read data holds
    wr(8'h70, 8'h55);
    rd(8'h70, `BGPC_PN_HIGH);
    rd(`BGPC_ADDR_INDEX, 8'h0b);
    final_report();
  end
endmodule
